// ===== btcr_pkg.sv
package btcr_pkg;

  // ==========================================================================
  // Register offsets.
  localparam logic [7:0] OFS_CHG_CTRL    = 8'hd0;
  localparam logic [7:0] OFS_DRAIN_PRI   = 8'hd1;
  localparam logic [7:0] OFS_DRAIN_CTRL  = 8'hd2;
  localparam logic [7:0] OFS_WARN_ABS_LO = 8'hd3;
  localparam logic [7:0] OFS_WARN_ABS_HI = 8'hd4;
  localparam logic [7:0] OFS_LOW_ABS_LO  = 8'hd5;
  localparam logic [7:0] OFS_LOW_ABS_HI  = 8'hd6;
  localparam logic [7:0] OFS_WARN_REL    = 8'hd7;
  localparam logic [7:0] OFS_LOW_REL     = 8'hd8;
  localparam logic [7:0] OFS_FULL_CANCEL = 8'hd9;
  localparam logic [7:0] OFS_CHG_CURRENT = 8'hda;
  localparam logic [7:0] OFS_TRIP2_LO    = 8'hdb;
  localparam logic [7:0] OFS_TRIP2_HI    = 8'hdc;
  localparam logic [7:0] OFS_PM_CTRL     = 8'he0;
  localparam logic [7:0] OFS_OS_MODE     = 8'he1;
  localparam logic [7:0] OFS_OFF_TIMER   = 8'he2;
  localparam logic [7:0] OFS_SENSOR_ADDR = 8'he3;
  localparam logic [7:0] OFS_HIGH_ALARM  = 8'he4;
  localparam logic [7:0] OFS_LOW_ALARM   = 8'he5;
  localparam logic [7:0] OFS_POLL_PERIOD = 8'he6;
  localparam logic [7:0] OFS_POLL_RESULT = 8'he7;
  localparam logic [7:0] OFS_SHUTDOWN    = 8'he8;
  localparam logic [7:0] OFS_SENSOR_CMD  = 8'he9;
  localparam logic [7:0] OFS_RETRY_LIMIT = 8'hea;
  localparam logic [7:0] OFS_THERM_EVT   = 8'haf;
  localparam logic [7:0] OFS_FLAG_FINISH = 8'hf0;

  // ==========================================================================
  // Reset values.
  localparam logic [7:0] RST_LOW_REL     = 8'h06;
  localparam logic [7:0] RST_FULL_CANCEL = 8'hbe;
  localparam logic [7:0] RST_OFF_TIMER   = 8'h64;
  localparam logic [7:0] RST_SHUTDOWN    = 8'h7d;
  localparam logic [7:0] RST_RETRY_LIMIT = 8'h10;

  // ==========================================================================
  // Field positions.
  localparam int BIT_CHARGE_OK_N = 4;
  localparam int BIT_KEEP_REGS   = 2;
  localparam int BIT_BAY_IND     = 1;
  localparam int BIT_POW_BLINK   = 0;
  localparam int BIT_OS_MODE     = 0;
  localparam int BIT_EVT_HIGH    = 0;
  localparam int BIT_EVT_LOW     = 1;
  localparam int BIT_EVT_ERR     = 2;

  // ==========================================================================
  // Timing at 50 MHz.
  localparam int CLK_HZ        = 50000000;
  localparam int POLL_STEP_MS  = 250;
  localparam int POLL_STEP_CYC = CLK_HZ / 1000 * POLL_STEP_MS;

  typedef enum logic [1:0]
  {
    BTCR_IDLE = 2'b00,
    BTCR_REQ  = 2'b01,
    BTCR_WAIT = 2'b11
  } btcr_poll_t;

  typedef struct packed
  {
    logic       start;
    logic [6:0] addr;
    logic [7:0] cmd;
  } btcr_sreq_t;

  typedef struct packed
  {
    logic       done;
    logic       ack;
    logic [7:0] data;
  } btcr_srsp_t;

endpackage

// ===== btcr_regs.sv
// Overview of operation
// - Poll period counts 250ms steps; code zero stops polling.
// - Seven-bit sensor address in upper bits; zero address disables polling.
// - Reading at or below low alarm limit raises low alarm event.
// - Reading at or above shutdown limit switches power off; limit resets 7Dh.
// - Last successful signed reading is held in the poll result register.
// - Command byte sent every poll; failed polls retried up to limit, reset 10h.
// - Override off timer counts 0.1s units, resets to 64h, zero reserved.
// - OS mode flag set means ACPI, clear means legacy; resets zero.
// - Keep-registers bit blocks host writes while power is off; device updates continue.
// - Bay indicator shows discharge status of each installed battery when enabled.
// - Second trip event when all capacities below nonzero setting and enabled.
// - Charging current register is read-only, 0.02A steps, zero means battery.
// - Relative thresholds are 0 to C8h in 0.5% steps; low resets 06h.
// - Absolute thresholds are 16-bit mWh, reset zero, compared with capacity.
// - Full-charge cancel point resets BEh and survives deep off states.
// - Drain order code maps 0,2,3,6 to 2-1; 1,4,5 to 1-2; 7 both.
// - One drain-select bit per battery; only one may be selected.
// - Charge control shows active-low charge-ok and per-battery charging flags.
// - Readback registers keep host writes until the device refreshes them.
// - Retained registers keep contents through S4-S5.
// - High alarm sets the high flag of the thermal event status.
// - Poll failure after all retries sets the thermal error flag.
`timescale 1ns/1ps
`default_nettype none

module btcr_regs
#(
  parameter int STEP_CYC = btcr_pkg::POLL_STEP_CYC
)
(
  input  wire logic              CORE_CLK,
  input  wire logic              RESET,
  input  wire logic [7:0]        ADDR,
  input  wire logic [7:0]        WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [7:0]        RDATA,
  input  wire logic              SYS_POWER_OFF,
  input  wire logic              DEEP_OFF,
  input  wire logic [1:0]        BATT_PRESENT,
  input  wire logic [1:0]        BATT_CHARGING,
  input  wire logic              CHARGE_OK_N,
  input  wire logic [15:0]       BATT1_CAPACITY,
  input  wire logic [15:0]       BATT2_CAPACITY,
  input  wire logic [7:0]        CHARGE_CURRENT,
  input  wire logic              TRIP2_ENABLE,
  output btcr_pkg::btcr_sreq_t   SENSOR_REQ,
  input  wire btcr_pkg::btcr_srsp_t SENSOR_RSP,
  output logic                   POWER_OFF,
  output logic      [1:0]        BAY_INDICATOR_N,
  output logic                   TRIP2_EVENT,
  output logic                   WARN_ABS_HIT,
  output logic                   LOW_ABS_HIT,
  output logic      [1:0]        DRAIN_ORDER,
  output logic                   OS_ACPI,
  output logic                   POWER_BLINK,
  output logic      [7:0]        OFF_TIMER_TENTHS
);
  import btcr_pkg::*;

  // ==========================================================================
  // State.
  typedef struct packed
  {
    logic [1:0]  chg_reg;
    logic [2:0]  pri_reg;
    logic [1:0]  drain_reg;
    logic [15:0] warn_abs_reg;
    logic [15:0] low_abs_reg;
    logic [7:0]  warn_rel_reg;
    logic [7:0]  low_rel_reg;
    logic [7:0]  full_reg;
    logic [15:0] trip2_reg;
    logic [2:0]  pmctl_reg;
    logic        os_reg;
    logic [7:0]  offt_reg;
    logic [7:0]  saddr_reg;
    logic [7:0]  hi_reg;
    logic [7:0]  lo_reg;
    logic [7:0]  period_reg;
    logic [7:0]  result_reg;
    logic [7:0]  shut_reg;
    logic [7:0]  cmd_reg;
    logic [7:0]  retry_reg;
    logic [2:0]  evt_reg;
    logic [7:0]  finish_reg;
    logic [7:0]  rdata_reg;
    logic        pwroff_reg;
    logic [23:0] tick_reg;
    logic [7:0]  steps_reg;
    logic [7:0]  tries_reg;
    btcr_poll_t  poll_reg;
    logic        start_reg;
    logic [1:0]  pres_s1_reg;
    logic [1:0]  pres_s2_reg;
    logic [1:0]  chg_s1_reg;
    logic [1:0]  chg_s2_reg;
    logic [1:0]  chg_s3_reg;
    logic        ok_s1_reg;
    logic        ok_s2_reg;
    logic        off_s1_reg;
    logic        off_s2_reg;
  } btcr_state_t;

  btcr_state_t st_reg;
  btcr_state_t st_next;
  logic        hold;
  logic        poll_on;
  logic        ev_high;
  logic        ev_low;
  logic        ev_shut;
  logic        ev_err;
  logic        good;

  assign poll_on = (st_reg.period_reg != 8'h00) && (st_reg.saddr_reg[7:1] != 7'h00);
  assign good    = (st_reg.poll_reg == BTCR_WAIT) && SENSOR_RSP.done && SENSOR_RSP.ack;
  assign ev_high = good && ($signed(SENSOR_RSP.data) >= $signed(st_reg.hi_reg));
  assign ev_low  = good && ($signed(SENSOR_RSP.data) <= $signed(st_reg.lo_reg));
  assign ev_shut = good && ($signed(SENSOR_RSP.data) >= $signed(st_reg.shut_reg));
  assign ev_err  = (st_reg.poll_reg == BTCR_WAIT) && SENSOR_RSP.done && !SENSOR_RSP.ack
                   && (st_reg.tries_reg >= st_reg.retry_reg);
  // Host writes are blocked through power-off if the keep-registers bit asks; deep off plays no part.
  assign hold = st_reg.off_s2_reg && st_reg.pmctl_reg[BIT_KEEP_REGS];

  always_comb
  begin
    st_next = st_reg;
    st_next.pres_s1_reg = BATT_PRESENT;
    st_next.pres_s2_reg = st_reg.pres_s1_reg;
    st_next.chg_s1_reg  = BATT_CHARGING;
    st_next.chg_s2_reg  = st_reg.chg_s1_reg;
    st_next.chg_s3_reg  = st_reg.chg_s2_reg;
    st_next.ok_s1_reg   = CHARGE_OK_N;
    st_next.ok_s2_reg   = st_reg.ok_s1_reg;
    st_next.off_s1_reg  = SYS_POWER_OFF;
    st_next.off_s2_reg  = st_reg.off_s1_reg;
    st_next.start_reg   = 1'b0;
    // Charging flags refresh only on change, so host writes read back until then.
    if (st_reg.chg_s3_reg != st_reg.chg_s2_reg)
    begin
      st_next.chg_reg = st_reg.chg_s2_reg;
    end

    // ------------------------------------------------------------------------
    // Poller.
    case (st_reg.poll_reg)
      BTCR_IDLE:
      begin
        if (!poll_on)
        begin
          st_next.tick_reg  = 24'h000000;
          st_next.steps_reg = 8'h00;
        end
        else if (st_reg.tick_reg == 24'(STEP_CYC - 1))
        begin
          st_next.tick_reg = 24'h000000;
          if (st_reg.steps_reg + 8'h01 >= st_reg.period_reg)
          begin
            st_next.steps_reg = 8'h00;
            st_next.tries_reg = 8'h00;
            st_next.poll_reg  = BTCR_REQ;
          end
          else
          begin
            st_next.steps_reg = st_reg.steps_reg + 8'h01;
          end
        end
        else
        begin
          st_next.tick_reg = st_reg.tick_reg + 24'h000001;
        end
      end
      BTCR_REQ:
      begin
        st_next.start_reg = 1'b1;
        st_next.poll_reg  = BTCR_WAIT;
      end
      BTCR_WAIT:
      begin
        if (SENSOR_RSP.done)
        begin
          if (SENSOR_RSP.ack)
          begin
            st_next.result_reg = SENSOR_RSP.data;
            st_next.poll_reg   = BTCR_IDLE;
          end
          else if (st_reg.tries_reg < st_reg.retry_reg)
          begin
            st_next.tries_reg = st_reg.tries_reg + 8'h01;
            st_next.poll_reg  = BTCR_REQ;
          end
          else
          begin
            st_next.poll_reg = BTCR_IDLE;
          end
        end
      end
      default:
      begin
        st_next.poll_reg = BTCR_IDLE;
      end
    endcase

    if (ev_shut)
    begin
      st_next.pwroff_reg = 1'b1;
    end

    // ------------------------------------------------------------------------
    // Register writes; a write is dropped while the registers are held.
    if (WR && !hold)
    begin
      case (ADDR)
        OFS_CHG_CTRL:    st_next.chg_reg = WDATA[1:0];
        OFS_DRAIN_PRI:   st_next.pri_reg = WDATA[2:0];
        OFS_DRAIN_CTRL:  st_next.drain_reg = (&WDATA[1:0]) ? st_reg.drain_reg
                                                            : WDATA[1:0];
        OFS_WARN_ABS_LO: st_next.warn_abs_reg[7:0]  = WDATA;
        OFS_WARN_ABS_HI: st_next.warn_abs_reg[15:8] = WDATA;
        OFS_LOW_ABS_LO:  st_next.low_abs_reg[7:0]   = WDATA;
        OFS_LOW_ABS_HI:  st_next.low_abs_reg[15:8]  = WDATA;
        OFS_WARN_REL:    st_next.warn_rel_reg = WDATA;
        OFS_LOW_REL:     st_next.low_rel_reg  = WDATA;
        OFS_FULL_CANCEL: st_next.full_reg     = WDATA;
        OFS_TRIP2_LO:    st_next.trip2_reg[7:0]  = WDATA;
        OFS_TRIP2_HI:    st_next.trip2_reg[15:8] = WDATA;
        OFS_PM_CTRL:     st_next.pmctl_reg  = WDATA[2:0];
        OFS_OS_MODE:     st_next.os_reg     = WDATA[BIT_OS_MODE];
        OFS_OFF_TIMER:   st_next.offt_reg = (WDATA == 8'h00) ? st_reg.offt_reg
                                                              : WDATA;
        OFS_SENSOR_ADDR: st_next.saddr_reg  = {WDATA[7:1], 1'b0};
        OFS_HIGH_ALARM:  st_next.hi_reg     = WDATA;
        OFS_LOW_ALARM:   st_next.lo_reg     = WDATA;
        OFS_POLL_PERIOD: st_next.period_reg = WDATA;
        OFS_POLL_RESULT: st_next.result_reg = good ? st_next.result_reg : WDATA;
        OFS_SHUTDOWN:    st_next.shut_reg   = WDATA;
        OFS_SENSOR_CMD:  st_next.cmd_reg    = WDATA;
        OFS_RETRY_LIMIT: st_next.retry_reg  = WDATA;
        OFS_THERM_EVT:   st_next.evt_reg    = st_reg.evt_reg & WDATA[2:0];
        OFS_FLAG_FINISH: st_next.finish_reg = WDATA;
        default:         st_next.finish_reg = st_reg.finish_reg;
      endcase
    end

    // Hardware sets win over a clearing write in the same cycle.
    if (ev_high)
    begin
      st_next.evt_reg[BIT_EVT_HIGH] = 1'b1;
    end
    if (ev_low)
    begin
      st_next.evt_reg[BIT_EVT_LOW] = 1'b1;
    end
    if (ev_err)
    begin
      st_next.evt_reg[BIT_EVT_ERR] = 1'b1;
    end

    // ------------------------------------------------------------------------
    // Read data, one cycle after the strobe.
    st_next.rdata_reg = 8'h00;
    if (RD)
    begin
      case (ADDR)
        OFS_CHG_CTRL:    st_next.rdata_reg = {3'h0, st_reg.ok_s2_reg, 2'h0, st_reg.chg_reg};
        OFS_DRAIN_PRI:   st_next.rdata_reg = {5'h00, st_reg.pri_reg};
        OFS_DRAIN_CTRL:  st_next.rdata_reg = {6'h00, st_reg.drain_reg};
        OFS_WARN_ABS_LO: st_next.rdata_reg = st_reg.warn_abs_reg[7:0];
        OFS_WARN_ABS_HI: st_next.rdata_reg = st_reg.warn_abs_reg[15:8];
        OFS_LOW_ABS_LO:  st_next.rdata_reg = st_reg.low_abs_reg[7:0];
        OFS_LOW_ABS_HI:  st_next.rdata_reg = st_reg.low_abs_reg[15:8];
        OFS_WARN_REL:    st_next.rdata_reg = st_reg.warn_rel_reg;
        OFS_LOW_REL:     st_next.rdata_reg = st_reg.low_rel_reg;
        OFS_FULL_CANCEL: st_next.rdata_reg = st_reg.full_reg;
        OFS_CHG_CURRENT: st_next.rdata_reg = CHARGE_CURRENT;
        OFS_TRIP2_LO:    st_next.rdata_reg = st_reg.trip2_reg[7:0];
        OFS_TRIP2_HI:    st_next.rdata_reg = st_reg.trip2_reg[15:8];
        OFS_PM_CTRL:     st_next.rdata_reg = {5'h00, st_reg.pmctl_reg};
        OFS_OS_MODE:     st_next.rdata_reg = {7'h00, st_reg.os_reg};
        OFS_OFF_TIMER:   st_next.rdata_reg = st_reg.offt_reg;
        OFS_SENSOR_ADDR: st_next.rdata_reg = st_reg.saddr_reg;
        OFS_HIGH_ALARM:  st_next.rdata_reg = st_reg.hi_reg;
        OFS_LOW_ALARM:   st_next.rdata_reg = st_reg.lo_reg;
        OFS_POLL_PERIOD: st_next.rdata_reg = st_reg.period_reg;
        OFS_POLL_RESULT: st_next.rdata_reg = st_reg.result_reg;
        OFS_SHUTDOWN:    st_next.rdata_reg = st_reg.shut_reg;
        OFS_SENSOR_CMD:  st_next.rdata_reg = st_reg.cmd_reg;
        OFS_RETRY_LIMIT: st_next.rdata_reg = st_reg.retry_reg;
        OFS_THERM_EVT:   st_next.rdata_reg = {5'h00, st_reg.evt_reg};
        OFS_FLAG_FINISH: st_next.rdata_reg = st_reg.finish_reg;
        default:         st_next.rdata_reg = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      // Deep off keeps the retained full-charge cancel point.
      st_reg             <= '0;
      st_reg.low_rel_reg <= RST_LOW_REL;
      st_reg.full_reg    <= DEEP_OFF ? st_reg.full_reg : RST_FULL_CANCEL;
      st_reg.offt_reg    <= RST_OFF_TIMER;
      st_reg.shut_reg    <= RST_SHUTDOWN;
      st_reg.retry_reg   <= RST_RETRY_LIMIT;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Outputs.
  assign RDATA              = st_reg.rdata_reg;
  assign SENSOR_REQ.start   = st_reg.start_reg;
  assign SENSOR_REQ.addr    = st_reg.saddr_reg[7:1];
  assign SENSOR_REQ.cmd     = st_reg.cmd_reg;
  assign POWER_OFF          = st_reg.pwroff_reg;
  assign OS_ACPI            = st_reg.os_reg;
  assign POWER_BLINK        = st_reg.pmctl_reg[BIT_POW_BLINK];
  assign OFF_TIMER_TENTHS   = st_reg.offt_reg;
  assign WARN_ABS_HIT       = (BATT1_CAPACITY < st_reg.warn_abs_reg)
                              || (BATT2_CAPACITY < st_reg.warn_abs_reg);
  assign LOW_ABS_HIT        = (BATT1_CAPACITY < st_reg.low_abs_reg)
                              || (BATT2_CAPACITY < st_reg.low_abs_reg);
  assign TRIP2_EVENT        = TRIP2_ENABLE && (st_reg.trip2_reg != 16'h0000)
                              && (BATT1_CAPACITY < st_reg.trip2_reg)
                              && (BATT2_CAPACITY < st_reg.trip2_reg);
  // Bit 0 means battery 2 drains first, bit 1 battery 1 first, both set: together.
  assign DRAIN_ORDER        = (st_reg.pri_reg == 3'h7) ? 2'b11 :
                              ((st_reg.pri_reg == 3'h1) || (st_reg.pri_reg == 3'h4)
                               || (st_reg.pri_reg == 3'h5)) ? 2'b10 : 2'b01;

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_bay
      assign BAY_INDICATOR_N[g] = !(st_reg.pmctl_reg[BIT_BAY_IND] && st_reg.pres_s2_reg[g]
                                    && st_reg.drain_reg[g]);
    end
  endgenerate

  // ==========================================================================
  // Checks.
  sequence s_fail_last;
    (st_reg.poll_reg == BTCR_WAIT) && SENSOR_RSP.done && !SENSOR_RSP.ack
      && (st_reg.tries_reg >= st_reg.retry_reg);
  endsequence

  chk_poll_idle_off: assert property (@(posedge CORE_CLK) disable iff (RESET)
    st_reg.period_reg == 8'h00 && st_reg.poll_reg == BTCR_IDLE |=> st_reg.poll_reg == BTCR_IDLE)
    else $error("poll started while disabled");
  chk_addr_zero: assert property (@(posedge CORE_CLK) disable iff (RESET)
    st_reg.saddr_reg[7:1] == 7'h00 && st_reg.poll_reg == BTCR_IDLE
      |=> st_reg.poll_reg == BTCR_IDLE)
    else $error("poll enabled with zero address");
  chk_low_alarm: assert property (@(posedge CORE_CLK) disable iff (RESET)
    good && $signed(SENSOR_RSP.data) <= $signed(st_reg.lo_reg) |=> st_reg.evt_reg[BIT_EVT_LOW])
    else $error("low alarm missed");
  chk_high_alarm: assert property (@(posedge CORE_CLK) disable iff (RESET)
    good && $signed(SENSOR_RSP.data) >= $signed(st_reg.hi_reg) |=> st_reg.evt_reg[BIT_EVT_HIGH])
    else $error("high alarm missed");
  chk_shut_power: assert property (@(posedge CORE_CLK) disable iff (RESET)
    ev_shut |=> POWER_OFF)
    else $error("shutdown missed");
  chk_result_hold: assert property (@(posedge CORE_CLK) disable iff (RESET)
    good |=> st_reg.result_reg == $past(SENSOR_RSP.data))
    else $error("result not stored");
  chk_retry_req: assert property (@(posedge CORE_CLK) disable iff (RESET)
    st_reg.poll_reg == BTCR_REQ |=> st_reg.start_reg && SENSOR_REQ.cmd == st_reg.cmd_reg)
    else $error("request not issued");
  chk_err_flag: assert property (@(posedge CORE_CLK) disable iff (RESET)
    s_fail_last |=> st_reg.evt_reg[BIT_EVT_ERR] && st_reg.poll_reg == BTCR_IDLE)
    else $error("error flag missed");
  chk_one_drain: assert property (@(posedge CORE_CLK) disable iff (RESET)
    st_reg.drain_reg != 2'b11)
    else $error("two batteries selected");
  chk_timer_nonzero: assert property (@(posedge CORE_CLK) disable iff (RESET)
    st_reg.offt_reg != 8'h00)
    else $error("reserved timer code");

endmodule

`default_nettype wire

// ===== btcr_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Thermal sensor stand-in: answers each poll after a fixed delay.
module btcr_sensor_model
#(
  parameter int         LATENCY = 3,
  parameter logic [7:0] TEMP    = 8'h2a
)
(
  input  wire logic                 clk,
  input  wire logic                 ack,
  input  wire btcr_pkg::btcr_sreq_t req,
  output var  btcr_pkg::btcr_srsp_t rsp
);
  import btcr_pkg::*;
  int   cnt  = 0;
  logic busy = 1'b0;
  initial rsp = '0;
  always @(posedge clk)
  begin
    rsp.done <= 1'b0;
    // A released data line inverts every cycle, so it shows the stale value every other cycle.
    rsp.data <= ~rsp.data;
    if (req.start)
    begin
      busy <= 1'b1;
      cnt  <= LATENCY;
    end
    else if (busy && cnt > 1)
      cnt <= cnt - 1;
    else if (busy)
    begin
      busy     <= 1'b0;
      rsp.done <= 1'b1;
      rsp.ack  <= ack;
      rsp.data <= TEMP;
    end
  end
endmodule

`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end

module testbench;
  import btcr_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} btcr_row_t;
  // ==========================================================================
  // Write, read back, expected read value.
  localparam btcr_row_t ROWS [21] = '{
    '{8'he6, 8'h01, 8'h01}, '{8'he3, 8'h01, 8'h00}, '{8'he4, 8'h40, 8'h40},
    '{8'he5, 8'hc0, 8'hc0}, '{8'he8, 8'h20, 8'h20}, '{8'he9, 8'h3c, 8'h3c},
    '{8'hea, 8'hff, 8'hff}, '{8'he1, 8'h01, 8'h01}, '{8'he2, 8'h01, 8'h01},
    '{8'he2, 8'h00, 8'h01}, '{8'hd7, 8'hc8, 8'hc8}, '{8'hd8, 8'h00, 8'h00},
    '{8'hd3, 8'h34, 8'h34}, '{8'hd4, 8'h12, 8'h12}, '{8'hdc, 8'hab, 8'hab},
    '{8'hf0, 8'h00, 8'h00}, '{8'ha0, 8'h5a, 8'h00}, '{8'hda, 8'h77, 8'h3c},
    '{8'hd2, 8'h01, 8'h01}, '{8'hd2, 8'h03, 8'h01}, '{8'he7, 8'h5a, 8'h5a}};
  localparam btcr_row_t RSTS [10] = '{
    '{8'hd9, 8'h00, 8'h55}, '{8'hd8, 8'h00, 8'h06}, '{8'he2, 8'h00, 8'h64},
    '{8'he8, 8'h00, 8'h7d}, '{8'hea, 8'h00, 8'h10}, '{8'he6, 8'h00, 8'h00},
    '{8'he3, 8'h00, 8'h00}, '{8'he1, 8'h00, 8'h00}, '{8'hd4, 8'h00, 8'h00},
    '{8'he7, 8'h00, 8'h00}};
  // Expected drain order per priority code, two bits per code, code 0 lowest.
  localparam logic [15:0] ORDERS = 16'hda59;

  logic        core_clk = 1'b0;
  logic        reset    = 1'b1;
  logic [7:0]  addr     = 8'h00;
  logic [7:0]  wdata    = 8'h00;
  logic        wr       = 1'b0;
  logic        rd       = 1'b0;
  logic        pwr_off  = 1'b0;
  logic        deep_off = 1'b0;
  logic        chg_ok_n = 1'b1;
  logic        trip2_en = 1'b0;
  logic [1:0]  present  = 2'b00;
  logic [1:0]  charging = 2'b00;
  logic [15:0] cap1     = 16'h0000;
  logic [15:0] cap2     = 16'h0000;
  logic [7:0]  chg_cur  = 8'h3c;
  logic        sens_ack = 1'b1;
  logic [7:0]  rdata, rd_val, off_tenths;
  logic [1:0]  bay_n, drain_order;
  logic        power_off, trip2, os_acpi, blink, warn_hit, low_hit;
  btcr_sreq_t  sreq;
  btcr_srsp_t  srsp;
  int          mismatches = 0;
  int          n_tests    = 0;

  always #10 core_clk = ~core_clk;

  btcr_sensor_model partner (.clk(core_clk), .ack(sens_ack), .req(sreq), .rsp(srsp));

  btcr_regs #(.STEP_CYC(8)) uut (.CORE_CLK(core_clk), .RESET(reset), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .SYS_POWER_OFF(pwr_off),
    .DEEP_OFF(deep_off),
    .BATT_PRESENT(present), .BATT_CHARGING(charging), .CHARGE_OK_N(chg_ok_n),
    .BATT1_CAPACITY(cap1), .BATT2_CAPACITY(cap2), .CHARGE_CURRENT(chg_cur),
    .TRIP2_ENABLE(trip2_en), .SENSOR_REQ(sreq), .SENSOR_RSP(srsp),
    .POWER_OFF(power_off), .BAY_INDICATOR_N(bay_n), .TRIP2_EVENT(trip2),
    .WARN_ABS_HIT(warn_hit), .LOW_ABS_HIT(low_hit), .DRAIN_ORDER(drain_order),
    .OS_ACPI(os_acpi), .POWER_BLINK(blink), .OFF_TIMER_TENTHS(off_tenths));

  // ==========================================================================
  // Bus cycles and run control.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    @(posedge core_clk);
    rd_val = rdata;
  endtask

  task automatic wait_sync;
    repeat (4) @(posedge core_clk);
  endtask

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    end_sim();
  end

  // ==========================================================================
  // Main sequence.
  initial
  begin
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    rd_reg(OFS_FULL_CANCEL);
    `CHK(rd_val, 8'hbe)
    foreach (ROWS[i])
    begin
      wr_reg(ROWS[i].a, ROWS[i].d);
      rd_reg(ROWS[i].a);
      `CHK(rd_val, ROWS[i].e)
    end
    `CHK(os_acpi, 1'b1)
    `CHK(off_tenths, 8'h01)
    for (int c = 0; c < 8; c++)
    begin
      wr_reg(OFS_DRAIN_PRI, 8'(c));
      `CHK(drain_order, ORDERS[2*c +: 2])
    end
    wr_reg(OFS_PM_CTRL, 8'h03);
    @(posedge core_clk);
    present <= 2'b01;
    wait_sync();
    `CHK(bay_n, 2'b10)
    `CHK(blink, 1'b1)
    present <= 2'b00;
    wait_sync();
    `CHK(bay_n, 2'b11)
    wr_reg(OFS_TRIP2_LO, 8'h00);
    wr_reg(OFS_TRIP2_HI, 8'h01);
    cap1     <= 16'h0080;
    cap2     <= 16'h00ff;
    trip2_en <= 1'b1;
    wait_sync();
    `CHK(trip2, 1'b1)
    `CHK(warn_hit, 1'b1)
    `CHK(low_hit, 1'b0)
    cap2 <= 16'h0100;
    wait_sync();
    `CHK(trip2, 1'b0)
    cap2 <= 16'h00ff;
    wr_reg(OFS_TRIP2_HI, 8'h00);
    `CHK(trip2, 1'b0)
    charging <= 2'b10;
    chg_ok_n <= 1'b0;
    wait_sync();
    rd_reg(OFS_CHG_CTRL);
    `CHK(rd_val, 8'h02)
    wr_reg(OFS_PM_CTRL, 8'h04);
    pwr_off <= 1'b1;
    wait_sync();
    wr_reg(OFS_POLL_PERIOD, 8'h07);
    rd_reg(OFS_POLL_PERIOD);
    `CHK(rd_val, 8'h01)
    pwr_off <= 1'b0;
    wait_sync();
    wr_reg(OFS_POLL_PERIOD, 8'h07);
    rd_reg(OFS_POLL_PERIOD);
    `CHK(rd_val, 8'h07)
    wr_reg(OFS_FULL_CANCEL, 8'h55);
    deep_off <= 1'b1;
    reset    <= 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    foreach (RSTS[i])
    begin
      rd_reg(RSTS[i].a);
      `CHK(rd_val, RSTS[i].e)
    end
    `CHK(power_off, 1'b0)
    // Two good polls reaching both alarms and the shutdown limit.
    wr_reg(OFS_SENSOR_ADDR, 8'h91);
    wr_reg(OFS_SENSOR_CMD, 8'h3c);
    wr_reg(OFS_HIGH_ALARM, 8'h2a);
    wr_reg(OFS_LOW_ALARM, 8'h2a);
    wr_reg(OFS_SHUTDOWN, 8'h2a);
    `CHK(sreq.addr, 7'h48)
    `CHK(sreq.cmd, 8'h3c)
    wr_reg(OFS_POLL_PERIOD, 8'h02);
    repeat (40) @(posedge core_clk);
    wr_reg(OFS_POLL_PERIOD, 8'h00);
    repeat (10) @(posedge core_clk);
    rd_reg(OFS_POLL_RESULT);
    `CHK(rd_val, 8'h2a)
    rd_reg(OFS_THERM_EVT);
    `CHK(rd_val, 8'h03)
    `CHK(power_off, 1'b1)
    // Failing polls run out of retries and raise the error flag.
    wr_reg(OFS_THERM_EVT, 8'h00);
    wr_reg(OFS_FLAG_FINISH, 8'h00);
    rd_reg(OFS_THERM_EVT);
    `CHK(rd_val, 8'h00)
    sens_ack <= 1'b0;
    wr_reg(OFS_RETRY_LIMIT, 8'h02);
    wr_reg(OFS_POLL_PERIOD, 8'h01);
    repeat (40) @(posedge core_clk);
    rd_reg(OFS_THERM_EVT);
    `CHK(rd_val, 8'h04)
    rd_reg(OFS_POLL_RESULT);
    `CHK(rd_val, 8'h2a)
    end_sim();
  end
endmodule

`default_nettype wire
